//--- rcs_pkg.sv
// Constants, types and behaviour notes shared by the reset, clock and standby control
//--------------------------------------------------------------------------
// Notes on behaviour
// [RQ1] A 32-bit read-only register reports the cause of the latest system reset.
// [RQ2] External reset loads the cause register with zero; watchdog overflow loads one.
// [RQ3] Watchdog reset flag reads 0 after external reset, 1 after watchdog overflow.
// [RQ4] Software writes zero to every reserved bit of the cause register.
// [RQ5] Internal reset holds while the external input is low and nine cycles after.
// [RQ6] External reset clears standby control to zero and leaves halt mode.
// [RQ7] The reset source holds reset long enough for oscillator and PLL to settle.
// [RQ8] Watchdog reset lasts nine cycles and keeps the clock divider setting.
// [RQ9] Watchdog reset clears the halt request, leaves halt, and sets cause to one.
// [RQ10] With PLL enabled, range strap high multiplies by four, low by two.
// [RQ11] Divider select 00 gives a quarter, 01 a half, 1X the full PLL rate.
// [RQ12] Software and board keep the core clock between 4 and 25 MHz.
// [RQ13] Writing one to the halt request bit stops the CPU; peripherals keep running.
// [RQ14] Halt ends on fast or normal interrupt, system reset, or debug request.
// [RQ15] A source at level zero never wakes; level one or more always wakes.
// [RQ16] A fast interrupt wakes from halt only while its mask bit is clear.
// [RQ17] Standby or divider writes take effect only right after an unlock key write.
// [RQ18] The halt request bit clears itself on every wake from halt.
// [RQ19] Reserved cause bits read zero; writes to the cause register do nothing.
//--------------------------------------------------------------------------
package rcs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STANDBY = 8'h00;
    localparam logic [7:0] OFS_CLKDIV = 8'h04;
    localparam logic [7:0] OFS_CAUSE = 8'h0c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h14;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;
    // Values and field positions
    localparam logic [31:0] UNLOCK_KEY = 32'h0000003c;
    localparam logic [31:0] CAUSE_EXT = 32'h00000000;
    localparam logic [31:0] CAUSE_WDT = 32'h00000001;
    localparam int HALT_BIT = 0;
    localparam logic [1:0] CKM_RESET = 2'h0;
    // Reset stretch counts: watchdog counts its trigger cycle as the first
    localparam logic [3:0] STRETCH_EXT = 4'h9;
    localparam logic [3:0] STRETCH_WDT = 4'h8;
    // Clock ratios
    localparam logic [2:0] MULT_HIGH = 3'h4;
    localparam logic [2:0] MULT_LOW = 3'h2;
    localparam logic [2:0] MULT_OFF = 3'h1;
    localparam logic [2:0] DIV_QUARTER = 3'h4;
    localparam logic [2:0] DIV_HALF = 3'h2;
    localparam logic [2:0] DIV_FULL = 3'h1;
    // Event status bits
    localparam int EVT_WIDTH = 3;
    localparam int EVT_WDT = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_REFUSED = 2;
    localparam int LEVEL_WIDTH = 3;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } run_state_e;

    typedef struct packed {
        logic fast_irq_req;
        logic fast_irq_mask;
        logic debug_request_pin;
        logic port_eight_secondary;
    } wake_misc_s;
endpackage

//--- reset_stretch.sv
// Internal reset stretcher for pin and watchdog reset sources
`timescale 1ns/100ps
module reset_stretch
    import rcs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Reset sources
    input wire logic ext_active,
    input wire logic wdt_pulse,
    // Stretched internal reset, high while active
    output logic rst_active
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // Pin holds the count full; watchdog loads one less since its cycle counts
    assign cnt_d = ext_active ? STRETCH_EXT : (wdt_pulse ? STRETCH_WDT :
                   ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0)); // [RQ5] [RQ8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            rst_active <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            rst_active <= ext_active | wdt_pulse | (cnt_q != 4'h0); // [RQ5]
        end
    end
endmodule // reset_stretch

//--- wake_detect.sv
// Halt wake condition from interrupt levels, fast interrupt and debug request
`timescale 1ns/100ps
module wake_detect
    import rcs_pkg::*;
#(
    parameter int NUM_SRC = 28
) (
    // Interrupt sources
    input wire logic [NUM_SRC-1:0] irq_pending,
    input wire logic [NUM_SRC*LEVEL_WIDTH-1:0] irq_level,
    input wire wake_misc_s misc,
    // Combined wake request
    output logic wake
);
    logic [NUM_SRC-1:0] src_wake;

    // Only a nonzero level wakes, whatever the current level is
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_src
            assign src_wake[i] = irq_pending[i] & (|irq_level[i*LEVEL_WIDTH +: LEVEL_WIDTH]); // [RQ15]
        end
    endgenerate

    assign wake = (|src_wake)
                | (misc.fast_irq_req & ~misc.fast_irq_mask) // [RQ16]
                | (misc.debug_request_pin & misc.port_eight_secondary); // [RQ14]
endmodule // wake_detect

//--- reset_clock_standby_ctrl.sv
// Reset cause, reset stretch, core clock ratio and halt mode control with APB slave
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module reset_clock_standby_ctrl
    import rcs_pkg::*;
#(
    parameter int NUM_SRC = 28
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset sources
    input wire logic external_reset_input_n,
    input wire logic watchdog_overflow,
    // Straps
    input wire logic pll_enable_strap,
    input wire logic pll_range_strap,
    // Wake sources
    input wire logic [NUM_SRC-1:0] irq_pending,
    input wire logic [NUM_SRC*LEVEL_WIDTH-1:0] irq_level,
    input wire wake_misc_s wake_misc,
    // Control outputs
    output logic internal_reset_n,
    output logic cpu_halt,
    output logic [2:0] pll_mult,
    output logic [2:0] core_div,
    output logic irq
);
    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic rst_active;
    logic wake;
    logic ext_act;
    logic wdt_ev;
    run_state_e state_q;
    run_state_e state_d;
    logic cause_q;
    logic [1:0] ckm_q;
    logic unlock_q;
    logic [EVT_WIDTH-1:0] evt_q;
    logic [EVT_WIDTH-1:0] evt_en_q;
    logic [EVT_WIDTH-1:0] evt_set;
    logic [EVT_WIDTH-1:0] evt_clr;
    logic [EVT_WIDTH-1:0] evt_d;
    logic [31:0] rdata_d;
    logic hit_d;
    logic [2:0] mult_d;
    logic [2:0] div_d;

    //--------------------------------------------------------------------------
    // Submodules
    //--------------------------------------------------------------------------
    // Pin low has priority; a watchdog pulse during pin reset adds nothing
    assign ext_act = ~external_reset_input_n;
    assign wdt_ev = watchdog_overflow & ~ext_act;

    reset_stretch u_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .ext_active(ext_act),
        .wdt_pulse(wdt_ev),
        .rst_active(rst_active)
    );

    wake_detect #(.NUM_SRC(NUM_SRC)) u_wake (
        .irq_pending(irq_pending),
        .irq_level(irq_level),
        .misc(wake_misc),
        .wake(wake)
    );

    assign internal_reset_n = ~rst_active; // [RQ5]

    //--------------------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------------------
    // Zero wait state: pready rises in the first access cycle
    wire setup_ph = psel & ~penable;
    wire wr_done = psel & penable & pready & pwrite;
    wire sel_stby = (paddr == OFS_STANDBY);
    wire sel_ckdv = (paddr == OFS_CLKDIV);
    wire sel_cause = (paddr == OFS_CAUSE);
    wire sel_stat = (paddr == OFS_EVT_STATUS);
    wire sel_clr = (paddr == OFS_EVT_CLEAR);
    wire sel_en = (paddr == OFS_EVT_ENABLE);
    wire sel_any = sel_stby | sel_ckdv | sel_cause | sel_stat | sel_clr | sel_en;
    wire is_key = (pwdata == UNLOCK_KEY);
    wire prot_sel = sel_stby | sel_ckdv;
    // A protected write lands only when the preceding write was the key
    wire prot_wr = wr_done & prot_sel & unlock_q; // [RQ17]
    wire key_wr = wr_done & prot_sel & ~unlock_q & is_key; // [RQ17]
    wire halt_req = prot_wr & sel_stby & pwdata[HALT_BIT]; // [RQ13]
    wire halt_take = halt_req & ~wake & ~rst_active;
    wire woke = (state_q == ST_HALT) & wake;

    // Read mux; write-only registers read zero
    always_comb begin
        rdata_d = 32'h0;
        hit_d = 1'b1;
        case (1'b1)
            sel_ckdv: rdata_d = {30'h0, ckm_q};
            sel_cause: rdata_d = cause_q ? CAUSE_WDT : CAUSE_EXT; // [RQ1] [RQ3] [RQ19]
            sel_stat: rdata_d = {{(32-EVT_WIDTH){1'b0}}, evt_q};
            sel_en: rdata_d = {{(32-EVT_WIDTH){1'b0}}, evt_en_q};
            sel_stby, sel_clr: rdata_d = 32'h0;
            default: hit_d = 1'b0;
        endcase
    end

    // Answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~hit_d;
            prdata <= (setup_ph & ~pwrite) ? rdata_d : 32'h0;
        end
    end

    //--------------------------------------------------------------------------
    // Unlock sequence
    //--------------------------------------------------------------------------
    // Any write other than the key drops the unlock, so the pair must be adjacent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_q <= 1'b0;
        end else if (ext_act | wdt_ev) begin
            unlock_q <= 1'b0;
        end else if (wr_done) begin
            unlock_q <= key_wr; // [RQ17]
        end
    end

    //--------------------------------------------------------------------------
    // Reset cause and divider select
    //--------------------------------------------------------------------------
    // Cause is hardware-owned; bus writes to it are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= 1'b0;
        end else if (ext_act) begin
            cause_q <= 1'b0; // [RQ2]
        end else if (wdt_ev) begin
            cause_q <= 1'b1; // [RQ2] [RQ9]
        end
    end

    // Watchdog leaves the divider alone so the clock rate survives it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ckm_q <= CKM_RESET;
        end else if (ext_act) begin
            ckm_q <= CKM_RESET;
        end else if (prot_wr & sel_ckdv) begin
            ckm_q <= pwdata[1:0]; // [RQ17]
        end
    end

    //--------------------------------------------------------------------------
    // Clock ratios
    //--------------------------------------------------------------------------
    assign mult_d = ~pll_enable_strap ? MULT_OFF :
                    (pll_range_strap ? MULT_HIGH : MULT_LOW); // [RQ10]
    assign div_d = ckm_q[1] ? DIV_FULL : (ckm_q[0] ? DIV_HALF : DIV_QUARTER); // [RQ11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_mult <= MULT_OFF;
            core_div <= DIV_QUARTER;
        end else begin
            pll_mult <= mult_d;
            core_div <= div_d;
        end
    end

    //--------------------------------------------------------------------------
    // Halt state
    //--------------------------------------------------------------------------
    // Halt bit is the state itself, so waking clears it with no extra flop
    always_comb begin
        case (state_q)
            ST_RUN: state_d = halt_take ? ST_HALT : ST_RUN; // [RQ13]
            ST_HALT: state_d = wake ? ST_RUN : ST_HALT; // [RQ14] [RQ18]
            default: state_d = ST_RUN;
        endcase
        if (ext_act | wdt_ev) begin
            state_d = ST_RUN; // [RQ6] [RQ9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
            cpu_halt <= 1'b0;
        end else begin
            state_q <= state_d;
            cpu_halt <= (state_d == ST_HALT);
        end
    end

    //--------------------------------------------------------------------------
    // Event status and interrupt
    //--------------------------------------------------------------------------
    // Set beats clear in the same cycle so no event is lost
    assign evt_set[EVT_WDT] = wdt_ev;
    assign evt_set[EVT_WAKE] = woke & ~ext_act & ~wdt_ev;
    assign evt_set[EVT_REFUSED] = halt_req & ~halt_take;
    assign evt_clr = (wr_done & sel_clr) ? pwdata[EVT_WIDTH-1:0] : '0;
    assign evt_d = (evt_q & ~evt_clr) | evt_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= '0;
            evt_en_q <= '0;
            irq <= 1'b0;
        end else begin
            evt_q <= evt_d;
            if (wr_done & sel_en) begin
                evt_en_q <= pwdata[EVT_WIDTH-1:0];
            end
            irq <= |(evt_d & ((wr_done & sel_en) ? pwdata[EVT_WIDTH-1:0] : evt_en_q));
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cause_ext_a: assert property (ext_act |=> (cause_q == 1'b0)) // [RQ2]
        else $error("Pin reset did not clear reset cause");

    cause_wdt_a: assert property (wdt_ev |=> cause_q ##0 (rdata_d == CAUSE_WDT || !sel_cause)) // [RQ9]
        else $error("Watchdog reset did not set reset cause");

    cause_read_a: assert property ((setup_ph && !pwrite && sel_cause) |=>
        (prdata == {31'h0, $past(cause_q)})) // [RQ3]
        else $error("Reset cause read returned wrong value");

    ext_hold_a: assert property ($rose(external_reset_input_n) |-> rst_active[*8]) // [RQ5]
        else $error("Internal reset released too early after pin reset");

    ext_end_a: assert property (($rose(external_reset_input_n) && !watchdog_overflow)
        ##1 (external_reset_input_n && !watchdog_overflow)[*8]
        ##1 (external_reset_input_n && !watchdog_overflow) |=> !rst_active) // [RQ5]
        else $error("Internal reset held too long after pin reset");

    wdt_len_a: assert property ((wdt_ev && !rst_active) |=> rst_active[*8]) // [RQ8]
        else $error("Watchdog reset shorter than nine cycles");

    wdt_end_a: assert property ((wdt_ev && !rst_active) ##1
        (!ext_act && !watchdog_overflow)[*8] ##1 (!ext_act && !watchdog_overflow)
        |=> !rst_active) // [RQ8]
        else $error("Watchdog reset longer than nine cycles");

    wdt_keep_a: assert property (wdt_ev |=> $stable(ckm_q)) // [RQ8]
        else $error("Watchdog reset changed the divider select");

    ext_clear_a: assert property (ext_act |=> (!cpu_halt && ckm_q == CKM_RESET)) // [RQ6]
        else $error("Pin reset left halt or divider set");

    halt_wake_a: assert property ((cpu_halt && wake) |=> !cpu_halt) // [RQ14]
        else $error("Halt did not end on wake request");

    fiq_mask_a: assert property ((cpu_halt && !wake && wake_misc.fast_irq_mask
        && !ext_act && !wdt_ev) |=> cpu_halt) // [RQ16]
        else $error("Masked fast interrupt ended halt");

    halt_lock_a: assert property ((wr_done && sel_stby && !unlock_q && !cpu_halt)
        |=> !cpu_halt) // [RQ17]
        else $error("Locked standby write entered halt");

    halt_entry_a: assert property ((halt_req && !wake && !rst_active && !ext_act && !wdt_ev)
        |=> cpu_halt) // [RQ13]
        else $error("Unlocked halt request ignored");

    div_map_a: assert property (core_div == ($past(ckm_q[1]) ? DIV_FULL :
        ($past(ckm_q[0]) ? DIV_HALF : DIV_QUARTER))) // [RQ11]
        else $error("Core divider does not follow divider select");

    mult_map_a: assert property ($past(presetn) |-> pll_mult == (!$past(pll_enable_strap) ? MULT_OFF :
        ($past(pll_range_strap) ? MULT_HIGH : MULT_LOW))) // [RQ10]
        else $error("PLL multiplier does not follow straps");

    cov_wdt_c: cover property (wdt_ev ##1 rst_active[*8] ##1 !rst_active);
    cov_halt_c: cover property (halt_take ##1 cpu_halt[*3] ##1 !cpu_halt);
    cov_unlock_c: cover property (key_wr ##[1:4] (prot_wr && sel_ckdv));
    cov_irq_c: cover property ($rose(irq));
endmodule // reset_clock_standby_ctrl

//--- board_model.sv
// Board-side model: pin reset source, watchdog pulse and clock straps
`timescale 1ns/100ps
module board_model (
    // Clock
    input wire logic pclk,
    // Reset sources and straps
    output logic external_reset_input_n,
    output logic watchdog_overflow,
    output logic pll_enable_strap,
    output logic pll_range_strap
);
    // Shortest pin reset, standing in for oscillator and PLL settle time
    localparam int MIN_HOLD = 4;

    // Idle board: pin released, PLL on with the low input range
    initial begin
        external_reset_input_n = 1'b1;
        watchdog_overflow = 1'b0;
        pll_enable_strap = 1'b1;
        pll_range_strap = 1'b1;
    end

    // Pin held low n cycles, never less than the settle time
    task automatic pin_reset(input int n);
        @(posedge pclk);
        external_reset_input_n <= 1'b0;
        repeat ((n < MIN_HOLD) ? MIN_HOLD : n) @(posedge pclk);
        external_reset_input_n <= 1'b1;
    endtask

    // One-cycle overflow pulse, as the watchdog gives it
    task automatic wdt_pulse();
        @(posedge pclk);
        watchdog_overflow <= 1'b1;
        @(posedge pclk);
        watchdog_overflow <= 1'b0;
    endtask

    // Straps are only paired with crystals that keep the core clock in band
    task automatic set_straps(input logic en, input logic rng);
        @(posedge pclk);
        pll_enable_strap <= en;
        pll_range_strap <= rng;
    endtask
endmodule // board_model

//--- test_reset_clock_standby_ctrl.sv
// Self-checking bench for the reset, clock and standby control block
`timescale 1ns/100ps
module test_reset_clock_standby_ctrl;
    import rcs_pkg::*;
    localparam int NSRC = 28;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ext_n, wdt, pen, prng, irst_n, cpu_halt;
    logic [NSRC-1:0] irq_pending;
    logic [NSRC*LEVEL_WIDTH-1:0] irq_level;
    wake_misc_s wake_misc;
    logic [2:0] pll_mult, core_div;
    int failures, n_checks, cyc, seed, exp_evt;

    // Clock at 10 MHz
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    board_model board (.pclk(pclk), .external_reset_input_n(ext_n),
        .watchdog_overflow(wdt), .pll_enable_strap(pen), .pll_range_strap(prng));

    reset_clock_standby_ctrl #(.NUM_SRC(NSRC)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_input_n(ext_n), .watchdog_overflow(wdt),
        .pll_enable_strap(pen), .pll_range_strap(prng), .irq_pending(irq_pending),
        .irq_level(irq_level), .wake_misc(wake_misc), .internal_reset_n(irst_n),
        .cpu_halt(cpu_halt), .pll_mult(pll_mult), .core_div(core_div), .irq(irq));

    //----------------------------------------------------------------
    // Shared tasks
    //----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    // APB transfer; pready and answer taken at the rising edge that completes it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = pready;
            rd = prdata;
            err = pslverr;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, rd, exp);
    endtask

    // Key first, reserved bits written as zero
    task automatic prot(input logic [7:0] a, input logic [31:0] d);
        wr(a, UNLOCK_KEY);
        wr(a, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Counts consecutive low samples of the internal reset
    task automatic count_low(output int c);
        c = 0;
        for (int w = 0; w < 60; w++) begin
            @(negedge pclk);
            if (irst_n === 1'b0) c++;
            else if (c > 0) break;
        end
    endtask

    task automatic do_halt();
        prot(OFS_STANDBY, 32'h1);
        settle(1);
        chk("halt entry", cpu_halt, 32'h1);
    endtask

    // Wake stimulus: kind 0 source level, 1 fast irq, 2 debug; ph 0 blocked, 1 waking
    task automatic drive_wake(input int kind, input int ph, input int src, input int lvl);
        logic [NSRC-1:0] p;
        logic [NSRC*LEVEL_WIDTH-1:0] l;
        wake_misc_s m;
        p = '0;
        l = '0;
        m = '0;
        if (kind == 0 && ph < 2) p[src] = 1'b1;
        if (kind == 0 && ph == 1) l[src*LEVEL_WIDTH +: LEVEL_WIDTH] = lvl[2:0];
        if (kind == 1 && ph < 2) m = '{1'b1, ph == 0, 1'b0, 1'b0};
        if (kind == 2 && ph < 2) m = '{1'b0, 1'b0, 1'b1, ph == 1};
        @(posedge pclk);
        irq_pending <= p;
        irq_level <= l;
        wake_misc <= m;
    endtask

    function automatic logic [2:0] div_of(input int k);
        return k[1] ? 3'h1 : (k[0] ? 3'h2 : 3'h4);
    endfunction

    //----------------------------------------------------------------
    // Main sequence
    //----------------------------------------------------------------
    initial begin
        int cnt, src, lvl;
        logic [31:0] rd;
        logic err;
        seed = 32'hd2a4;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {irq_pending, irq_level, wake_misc} = '0;
        {failures, n_checks, cyc, exp_evt} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        fork
            board.pin_reset(6);
            count_low(cnt);
        join
        chk("pin stretch", cnt, 32'd15);
        rdchk("cause", OFS_CAUSE, CAUSE_EXT);
        wr(OFS_CAUSE, 32'h1);
        rdchk("cause ro", OFS_CAUSE, CAUSE_EXT);
        rdchk("status", OFS_EVT_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk("unmapped err", err, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test reset_values finished");
        for (int i = 0; i < 4; i++) begin
            board.set_straps(i[1], i[0]);
            settle(2);
            chk("pll mult", pll_mult, i[1] ? (i[0] ? 3'h4 : 3'h2) : 3'h1);
        end
        $display("test straps finished");
        wr(OFS_CLKDIV, 32'h2);
        settle(1);
        chk("locked div", core_div, 32'h4);
        for (int k = 0; k < 4; k++) begin
            prot(OFS_CLKDIV, k);
            settle(1);
            chk("core div", core_div, div_of(k));
            rdchk("div reg", OFS_CLKDIV, k);
        end
        $display("test divider finished");
        for (int k = 0; k < 3; k++) begin
            src = $unsigned($random(seed)) % NSRC;
            lvl = 1 + $unsigned($random(seed)) % 7;
            do_halt();
            drive_wake(k, 0, src, lvl);
            settle(3);
            chk("held", cpu_halt, 32'h1);
            drive_wake(k, 1, src, lvl);
            settle(3);
            chk("woke", cpu_halt, 32'h0);
            drive_wake(k, 2, src, lvl);
            settle(3);
            chk("stays awake", cpu_halt, 32'h0);
            exp_evt |= 2;
        end
        drive_wake(0, 1, src, lvl);
        prot(OFS_STANDBY, 32'h1);
        settle(2);
        chk("refused", cpu_halt, 32'h0);
        exp_evt |= 4;
        drive_wake(0, 2, src, lvl);
        rdchk("status", OFS_EVT_STATUS, exp_evt);
        $display("test halt finished");
        wr(OFS_EVT_ENABLE, 32'h2);
        settle(2);
        chk("irq on", irq, 32'h1);
        wr(OFS_EVT_ENABLE, 32'h0);
        settle(2);
        chk("irq masked", irq, 32'h0);
        wr(OFS_EVT_ENABLE, 32'h7);
        wr(OFS_EVT_CLEAR, 32'h7);
        settle(2);
        chk("irq cleared", irq, 32'h0);
        rdchk("status clr", OFS_EVT_STATUS, 32'h0);
        rdchk("enable", OFS_EVT_ENABLE, 32'h7);
        $display("test interrupt finished");
        prot(OFS_CLKDIV, 32'h2);
        do_halt();
        fork
            board.wdt_pulse();
            count_low(cnt);
        join
        chk("wdt stretch", cnt, 32'd9);
        chk("wdt wake", cpu_halt, 32'h0);
        chk("div kept", core_div, 32'h1);
        rdchk("cause wdt", OFS_CAUSE, CAUSE_WDT);
        chk("wdt irq", irq, 32'h1);
        rdchk("status wdt", OFS_EVT_STATUS, 32'h1);
        wr(OFS_EVT_CLEAR, 32'h1);
        $display("test watchdog finished");
        do_halt();
        fork
            board.pin_reset(8);
            count_low(cnt);
        join
        chk("pin stretch", cnt, 32'd17);
        chk("pin wake", cpu_halt, 32'h0);
        chk("div reset", core_div, 32'h4);
        rdchk("cause pin", OFS_CAUSE, CAUSE_EXT);
        rdchk("div reg", OFS_CLKDIV, 32'h0);
        $display("test pin_reset finished");
        end_sim();
    end
endmodule // test_reset_clock_standby_ctrl
